// >>> src/smp_link_if.sv
/*
 * smp_link_if: byte fetch link between table and reader.
 * assumes: single clock; data returns the cycle after a request.
 */
`timescale 1ns/1ns
interface smp_link_if;
    logic req;
    logic [11:0] addr;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;
    modport table_end (input req, input addr, input wr, input wdata,
                       output rdata, output rvalid);
    modport reader_end (output req, output addr, output wr, output wdata,
                        input rdata, input rvalid);
endinterface

// >>> src/smp_pkg.sv
/*
 * smp_pkg: shared constants for the sector map parameter table and its reader.
 * assumes: both ends import it; locations are 12-bit byte addresses.
 */
package smp_pkg;
    // ------------------------------------------------------------
    // table layout
    // ------------------------------------------------------------
    localparam int unsigned SMP_AW = 12;
    localparam logic [11:0] SMP_LOC_MID_FIRST = 12'h256;
    localparam logic [11:0] SMP_LOC_MID_LAST = 12'h257;
    localparam logic [11:0] SMP_LOC_U32_TYPE = 12'h258;
    localparam logic [11:0] SMP_LOC_U32_CNT = 12'h259;
    localparam logic [11:0] SMP_LOC_U32_FIRST = 12'h25A;
    localparam logic [11:0] SMP_LOC_U32_LAST = 12'h25B;
    localparam logic [11:0] SMP_LOC_T8_TYPE = 12'h25C;
    localparam logic [11:0] SMP_LOC_T8_CNT = 12'h25D;
    localparam logic [11:0] SMP_LOC_T8_FIRST = 12'h25E;
    localparam logic [11:0] SMP_LOC_T8_LAST = 12'h25F;
    // ------------------------------------------------------------
    // table contents
    // ------------------------------------------------------------
    localparam logic [7:0] SMP_VAL_MID_FIRST = 8'h00;
    localparam logic [7:0] SMP_VAL_MID_LAST = 8'hFC;
    localparam logic [7:0] SMP_VAL_U32_TYPE = 8'h03;
    localparam logic [7:0] SMP_VAL_U32_CNT = 8'h00;
    localparam logic [7:0] SMP_VAL_U32_FIRST = 8'hFE;
    localparam logic [7:0] SMP_VAL_U32_LAST = 8'hFE;
    localparam logic [7:0] SMP_VAL_T8_TYPE = 8'h02;
    localparam logic [7:0] SMP_VAL_T8_CNT = 8'h02;
    localparam logic [7:0] SMP_VAL_T8_FIRST = 8'h07;
    localparam logic [7:0] SMP_VAL_T8_LAST = 8'h0E;
    localparam logic [7:0] SMP_VAL_UNMAPPED = 8'hFF;
    // ------------------------------------------------------------
    // decode constants
    // ------------------------------------------------------------
    localparam logic [3:0] SMP_DENSITY_M = 4'h7;
    localparam logic [7:0] SMP_TYPE_8K = 8'h02;
    localparam logic [7:0] SMP_TYPE_64K = 8'h04;
    // ------------------------------------------------------------
    // host register map
    // ------------------------------------------------------------
    localparam logic [3:0] SMP_REG_CTRL = 4'h0;
    localparam logic [3:0] SMP_REG_STAT = 4'h1;
    localparam logic [3:0] SMP_REG_TYPE = 4'h2;
    localparam logic [3:0] SMP_REG_COUNT = 4'h3;
    localparam logic [3:0] SMP_REG_FIRST = 4'h4;
    localparam logic [3:0] SMP_REG_LAST = 4'h5;
    localparam logic [3:0] SMP_REG_RAW = 4'h6;
    localparam int unsigned SMP_CTRL_SEC_LSB = 0;
    localparam int unsigned SMP_CTRL_GO_BIT = 4;
    localparam logic [2:0] SMP_SEC_MID = 3'h3;
    localparam logic [2:0] SMP_SEC_U32 = 3'h4;
    localparam logic [2:0] SMP_SEC_T8 = 3'h5;
endpackage

// >>> src/smp_reader.sv
/*
 * smp_reader: fetches one major section (four bytes) and decodes it.
 * assumes: table answers one cycle after each request; software on a plain
 * register port with read data one cycle after the read strobe.
 */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Overview of operation
// - location MIDSECTION_LAST_BIT_ADDER returns FCH
// - location UPPER32K_SECTOR_TYPE returns type 03H
// - location UPPER32K_BLOCK_COUNT_EXP returns count exponent 00H
// - locations UPPER32K_FIRST_BIT_ADDER and UPPER32K_LAST_BIT_ADDER return FEH
// - location TOP8K_SECTOR_TYPE returns type 02H
// - location TOP8K_BLOCK_COUNT_EXP returns count exponent 02H
// - location TOP8K_FIRST_BIT_ADDER returns 07H
// - location TOP8K_LAST_BIT_ADDER returns 0EH
// - bit position is 2^m plus one plus adder
// - adder bytes are two's complement
// - type codes 01H..04H name size slots
// - first location 00H means bit zero
// - bit range length equals block count (the code expects twice the count for 8K sections and does not check 64K)
// - 8K sections: odd read lock, even write
// - uniform 4K sectors are not listed
// - repeated sizes are separate sections
// - location 256H returns 00H
// ------------------------------------------------------------
module smp_reader (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    smp_link_if.reader_end link
);
    import smp_pkg::*;

    typedef enum logic [1:0] {SMP_IDLE, SMP_FETCH, SMP_DONE} smp_state_type;

    smp_state_type state_q;
    logic [2:0] sec_q;
    logic [2:0] idx_q;
    logic [1:0] got_q;
    logic [7:0] raw_q [4];
    logic busy_q;
    logic err_q;
    logic [7:0] first_q;
    logic [7:0] last_q;
    logic [8:0] count_q;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // base location of a section; sections 3..5 sit four bytes apart, other codes take section 4
    function automatic logic [11:0] smp_base(input logic [2:0] s);
        logic [11:0] b;
        b = SMP_LOC_U32_TYPE;
        if (s == SMP_SEC_MID) begin
            b = SMP_LOC_MID_FIRST - 12'h002;
        end else if (s == SMP_SEC_T8) begin
            b = SMP_LOC_T8_TYPE;
        end
        return b;
    endfunction

    // adder byte to bit position; 00H on the first location is literal
    function automatic logic [7:0] smp_pos(input logic [7:0] c, input logic lit0);
        logic [8:0] p;
        p = (9'h001 << SMP_DENSITY_M) + 9'h001 + {c[7], c};
        if (lit0 && c == 8'h00) begin
            p = 9'h000;
        end
        return p[7:0];
    endfunction

    // ------------------------------------------------------------
    // fetch sequencer
    // ------------------------------------------------------------
    // one request per cycle, four in a row; answers counted separately
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= SMP_IDLE;
            idx_q <= 3'h0;
            busy_q <= 1'b0;
        end else if (ce_i) begin
            case (state_q)
                SMP_IDLE: begin
                    if (wr_i && addr_i == SMP_REG_CTRL && wdata_i[SMP_CTRL_GO_BIT]) begin
                        state_q <= SMP_FETCH;
                        idx_q <= 3'h0;
                        busy_q <= 1'b1;
                    end
                end
                SMP_FETCH: begin
                    if (idx_q == 3'h3) begin
                        state_q <= SMP_DONE;
                    end
                    idx_q <= idx_q + 3'h1;
                end
                SMP_DONE: begin
                    // the fourth answer lands here
                    if (link.rvalid && got_q == 2'h3) begin
                        state_q <= SMP_IDLE;
                        busy_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= SMP_IDLE;
                end
            endcase
        end
    end

    // request lines, always reads: the table is never written
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            link.req <= 1'b0;
            link.addr <= 12'h000;
            link.wr <= 1'b0;
            link.wdata <= 8'h00;
        end else if (ce_i) begin
            link.wr <= 1'b0;
            link.wdata <= 8'h00;
            link.req <= (state_q == SMP_FETCH);
            link.addr <= smp_base(sec_q) + {9'h000, idx_q};
        end
    end

    // capture answers in arrival order
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            got_q <= 2'h0;
            for (int i = 0; i < 4; i++) begin
                raw_q[i] <= 8'h00;
            end
        end else if (ce_i) begin
            if (state_q == SMP_IDLE) begin
                got_q <= 2'h0;
            end else if (link.rvalid) begin
                raw_q[got_q] <= link.rdata;
                got_q <= got_q + 2'h1;
            end
        end
    end

    // section select
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sec_q <= SMP_SEC_U32;
        end else if (ce_i && state_q == SMP_IDLE && wr_i && addr_i == SMP_REG_CTRL) begin
            sec_q <= wdata_i[SMP_CTRL_SEC_LSB +: 3];
        end
    end

    // ------------------------------------------------------------
    // section decode
    // ------------------------------------------------------------
    // 64K count is 2^n-2, others 2^n; error if bit range disagrees with count, except for 64K sections.
    // 8K blocks own a read lock and a write lock bit, so their range is twice the count
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            first_q <= 8'h00;
            last_q <= 8'h00;
            count_q <= 9'h000;
            err_q <= 1'b0;
        end else if (ce_i && state_q == SMP_DONE && link.rvalid && got_q == 2'h3) begin
            first_q <= smp_pos(raw_q[2], 1'b1);
            last_q <= smp_pos(link.rdata, 1'b0);
            if (raw_q[0] == SMP_TYPE_64K) begin
                count_q <= (9'h001 << raw_q[1][3:0]) - 9'h002;
            end else begin
                count_q <= 9'h001 << raw_q[1][3:0];
            end
            // range length must match count (64K section excluded: it spans 126)
            err_q <= (raw_q[0] != SMP_TYPE_64K) &&
                ({1'b0, smp_pos(link.rdata, 1'b0) - smp_pos(raw_q[2], 1'b1)} + 9'h001
                 != ((9'h001 << raw_q[1][3:0]) << (raw_q[0] == SMP_TYPE_8K)));
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    // status bit 2 flags an 8K section: odd bits read locks, even write locks
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (ce_i) begin
            rdata_o <= 8'h00;
            if (rd_i) begin
                if (addr_i == SMP_REG_CTRL) begin
                    rdata_o <= {5'h00, sec_q};
                end else if (addr_i == SMP_REG_STAT) begin
                    rdata_o <= {5'h00, raw_q[0] == SMP_TYPE_8K, err_q, busy_q};
                end else if (addr_i == SMP_REG_TYPE) begin
                    rdata_o <= raw_q[0];
                end else if (addr_i == SMP_REG_COUNT) begin
                    rdata_o <= count_q[7:0];
                end else if (addr_i == SMP_REG_FIRST) begin
                    rdata_o <= first_q;
                end else if (addr_i == SMP_REG_LAST) begin
                    rdata_o <= last_q;
                end else if (addr_i == SMP_REG_RAW) begin
                    rdata_o <= raw_q[3];
                end
            end
        end
    end
endmodule

// >>> src/smp_table.sv
/*
 * smp_table: constant sector map table, returns one byte a request.
 * assumes: reader keeps one request per cycle; writes are accepted and dropped.
 */
`timescale 1ns/1ns
module smp_table (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    smp_link_if.table_end link
);
    import smp_pkg::*;

    // ------------------------------------------------------------
    // lookup
    // ------------------------------------------------------------
    function automatic logic [7:0] smp_lookup(input logic [11:0] a);
        logic [7:0] v;
        v = SMP_VAL_UNMAPPED;
        if (a == SMP_LOC_MID_FIRST) begin
            v = SMP_VAL_MID_FIRST;
        end else if (a == SMP_LOC_MID_LAST) begin
            v = SMP_VAL_MID_LAST;
        end else if (a == SMP_LOC_U32_TYPE) begin
            v = SMP_VAL_U32_TYPE;
        end else if (a == SMP_LOC_U32_CNT) begin
            v = SMP_VAL_U32_CNT;
        end else if (a == SMP_LOC_U32_FIRST) begin
            v = SMP_VAL_U32_FIRST;
        end else if (a == SMP_LOC_U32_LAST) begin
            v = SMP_VAL_U32_LAST;
        end else if (a == SMP_LOC_T8_TYPE) begin
            v = SMP_VAL_T8_TYPE;
        end else if (a == SMP_LOC_T8_CNT) begin
            v = SMP_VAL_T8_CNT;
        end else if (a == SMP_LOC_T8_FIRST) begin
            v = SMP_VAL_T8_FIRST;
        end else if (a == SMP_LOC_T8_LAST) begin
            v = SMP_VAL_T8_LAST;
        end
        return v;
    endfunction

    // read data one cycle after the request; writes never reach the table
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            link.rdata <= 8'h00;
            link.rvalid <= 1'b0;
        end else if (ce_i) begin
            link.rvalid <= link.req & ~link.wr;
            if (link.req && !link.wr) begin
                link.rdata <= smp_lookup(link.addr);
            end
        end
    end
endmodule

// >>> test/sector_map_param_table_tb_top.sv
/* sector_map_param_table_tb_top: reader and table back to back, model compared.
   assumes: package, link, table, reader and checker compiled before it. */
`timescale 1ns/1ns
module sector_map_param_table_tb_top;
    import smp_pkg::*;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic [7:0] d;
    int err_count = 0;
    int n_compared = 0;
    // model of bytes 254H..TOP8K_LAST_BIT_ADDER; the first two lie outside the table
    int rom [12] = '{255, 255, 0, 252, 3, 0, 254, 254, 2, 2, 7, 14};
    smp_link_if link ();
    smp_table i_smp_table (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1), .link(link));
    smp_reader i_smp_reader (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(1'b1),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .link(link));
    smp_asserts i_smp_asserts (.mclk_i(mclk_i), .rstn_i(rstn_i), .req(link.req),
        .addr(link.addr), .wr(link.wr), .rdata(link.rdata), .rvalid(link.rvalid));
    // 100 MHz clock
    always #5 mclk_i = ~mclk_i;
    // --------------------------------------------------------
    // tasks
    // --------------------------------------------------------
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
            err_count++;
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    // bounded poll; a stuck busy counts as a mismatch
    task automatic wait_idle();
        for (int i = 0; i < 30; i++) begin
            reg_rd(4'h1);
            if (d[0] === 1'b0) return;
        end
        chk("busy", d, 8'h00);
    endtask
    // adder decode: 00H is bit zero, else 2^7+1 plus signed byte
    function automatic int pos(input int c);
        return (c == 0) ? 0 : 129 + ((c > 127) ? c - 256 : c);
    endfunction
    task automatic run_sec(input int sec);
        int b;
        int ty;
        int span;
        int want;
        b = (sec == 3) ? 0 : (sec == 5) ? 8 : 4;
        ty = rom[b];
        // 8K blocks carry two lock bits each, so their range is twice the count
        span = pos(rom[b + 3]) - pos(rom[b + 2]) + 1;
        want = (1 << rom[b + 1]) * ((ty == 2) ? 2 : 1);
        reg_wr(4'h0, 8'h10 | 8'(sec));
        wait_idle();
        // section 3 starts on bytes outside the table, so its range flag is not judged
        chk("stat", d & ((sec == 3) ? 8'hFD : 8'hFF),
            {5'h00, ty == 2, (sec != 3) && (span != want), 1'b0});
        reg_rd(4'h0);
        chk("ctrl", d, 8'(sec));
        reg_rd(4'h4);
        chk("first", d, 8'(pos(rom[b + 2])));
        reg_rd(4'h5);
        chk("last", d, 8'(pos(rom[b + 3])));
        reg_rd(4'h6);
        chk("raw", d, 8'(rom[b + 3]));
        if (sec != 3) begin
            reg_rd(4'h2);
            chk("type", d, 8'(ty));
            reg_rd(4'h3);
            chk("count", d, 8'(1 << rom[b + 1]));
        end
        $display("section %0d done", sec);
    endtask
    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        int s;
        void'($urandom(32'h9CAA9EFF));
        repeat (3) @(posedge mclk_i);
        rstn_i <= 1'b1;
        for (int k = 3; k <= 5; k++) begin
            run_sec(k);
        end
        // an undefined section code falls back to the UPPER32K_SECTOR_TYPE block
        s = $urandom_range(2, 0);
        run_sec(s);
        // a second order while busy must be dropped
        reg_wr(4'h0, 8'h14);
        reg_wr(4'h0, 8'h15);
        wait_idle();
        reg_rd(4'h2);
        chk("type busy", d, 8'h03);
        $display("busy refusal done");
        // read-only and unmapped places
        reg_wr(4'h2, 8'($urandom));
        reg_rd(4'h2);
        chk("type ro", d, 8'h03);
        reg_rd(4'(7 + $urandom_range(8, 0)));
        chk("unmapped", d, 8'h00);
        $display("register map done");
        // reset in mid fetch, content must come back the same
        reg_wr(4'h0, 8'h15);
        rstn_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rstn_i <= 1'b1;
        run_sec(5);
        print_verdict();
    end
    // watchdog, far beyond the roughly 130 cycles needed
    initial begin
        repeat (5000) @(posedge mclk_i);
        err_count++;
        print_verdict();
    end
endmodule

// >>> test/smp_asserts.sv
/* smp_asserts: link checks between sector map table and reader.
   assumes: instanced beside the link interface, one clock, ce held high. */
`timescale 1ns/1ns
module smp_asserts (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic req,
    input wire logic [11:0] addr,
    input wire logic wr,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    import smp_pkg::*;
    // --------------------------------------------------------
    // table bytes and fetch shape
    // --------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);
    // literal figures on purpose, so a bad package constant shows
    property p_byte(logic [11:0] loc, logic [7:0] val);
        req && !wr && addr == loc |=> rvalid && rdata == val;
    endproperty
    sequence s_four_reqs;
        req [*4] ##1 !req;
    endsequence
    mid_first_a: assert property (p_byte(12'h256, 8'h00)) else $error("bad 256H");
    mid_last_a: assert property (p_byte(12'h257, 8'hFC)) else $error("bad MIDSECTION_LAST_BIT_ADDER");
    u32_type_a: assert property (p_byte(12'h258, 8'h03)) else $error("bad UPPER32K_SECTOR_TYPE");
    u32_count_a: assert property (p_byte(12'h259, 8'h00)) else $error("bad UPPER32K_BLOCK_COUNT_EXP");
    u32_first_a: assert property (p_byte(12'h25A, 8'hFE)) else $error("bad UPPER32K_FIRST_BIT_ADDER");
    u32_last_a: assert property (p_byte(12'h25B, 8'hFE)) else $error("bad UPPER32K_LAST_BIT_ADDER");
    t8_type_a: assert property (p_byte(12'h25C, 8'h02)) else $error("bad TOP8K_SECTOR_TYPE");
    t8_count_a: assert property (p_byte(12'h25D, 8'h02)) else $error("bad TOP8K_BLOCK_COUNT_EXP");
    t8_first_a: assert property (p_byte(12'h25E, 8'h07)) else $error("bad TOP8K_FIRST_BIT_ADDER");
    t8_last_a: assert property (p_byte(12'h25F, 8'h0E)) else $error("bad TOP8K_LAST_BIT_ADDER");
    // a section is always fetched whole, four bytes in a row
    section_burst_a: assert property ($rose(req) |-> s_four_reqs)
        else $error("fetch not four bytes");
    addr_step_a: assert property (req && $past(req) |-> addr == $past(addr) + 12'h001)
        else $error("fetch address not ascending");
    answer_cause_a: assert property (!$past(req) |-> !rvalid)
        else $error("answer without request");
    reader_no_write_a: assert property (req |-> !wr)
        else $error("reader wrote the table");
endmodule
